// file: inc/tbh_pkg.sv
package tbh_pkg;
  // ==========================================
  // stream carriers
  typedef struct packed {
    logic vld;
    logic last;
    logic [7:0] data;
  } tbh_byte_s;

  typedef enum logic [2:0] {
    TBH_SEL_NONE = 3'h0,
    TBH_SEL_EF = 3'h1,
    TBH_SEL_APP = 3'h2,
    TBH_SEL_CC = 3'h3,
    TBH_SEL_NDEF = 3'h4
  } tbh_sel_e;

  // ==========================================
  // command codes and answers
  localparam logic [7:0] TBH_CMD_ATTRIB = 8'h1d;
  localparam logic [7:0] TBH_CMD_HALT = 8'h50;
  localparam logic [3:0] TBH_MBLI = 4'h1;
  localparam logic [3:0] TBH_CID_NONE = 4'h0;
  localparam logic [7:0] TBH_HALT_ANS = 8'h00;
  localparam logic [7:0] TBH_CLA = 8'h00;
  localparam logic [7:0] TBH_INS_SELECT = 8'ha4;
  localparam logic [7:0] TBH_INS_READ = 8'hb0;
  localparam logic [15:0] TBH_P12_EF = 16'h020c;
  localparam logic [15:0] TBH_P12_APP = 16'h0400;
  localparam logic [15:0] TBH_P12_FID = 16'h000c;
  localparam logic [7:0] TBH_LC_APP = 8'h07;
  localparam logic [7:0] TBH_LC_FID = 8'h02;
  localparam logic [7:0] TBH_LE_APP = 8'h00;
  localparam logic [55:0] TBH_AID = 56'hd2760000850101;
  localparam logic [15:0] TBH_FID_CC = 16'he103;
  localparam logic [15:0] TBH_FID_NDEF = 16'h0103;
  localparam logic [7:0] TBH_LE_MIN = 8'h01;
  localparam logic [7:0] TBH_LE_MAX = 8'hfb;

  // ==========================================
  // frame lengths without crc, buffer depth
  localparam logic [4:0] TBH_LEN_HALT = 5'h05;
  localparam logic [4:0] TBH_LEN_HDR = 5'h05;
  localparam logic [4:0] TBH_LEN_APP = 5'h0d;
  localparam logic [4:0] TBH_LEN_FID = 5'h07;
  localparam logic [4:0] TBH_LEN_CRC = 5'h02;
  localparam logic [4:0] TBH_BUF_DEPTH = 5'h10;

  // ==========================================
  // crc_b: reflected 0x1021, preset ffff, good residue f0b8
  localparam logic [15:0] TBH_CRC_INIT = 16'hffff;
  localparam logic [15:0] TBH_CRC_POLY = 16'h8408;
  localparam logic [15:0] TBH_CRC_GOOD = 16'hf0b8;

  function automatic logic [15:0] tbh_crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ TBH_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// file: rtl/tbh_core.sv
`timescale 1ns/100ps
// Summary of operation
// - attrib answer is one byte, upper nibble 0001b, then crc_b.
// - attrib answer lower nibble is 0000b, no cid support.
// - halt with matching pupi enters halt state, answers 0x00 plus crc_b.
// - select and read with class byte not 0x00 get an error status.
// - select is 0xa4; only p1p2 020c, 0400, 000c accepted.
// - select lc is 07 for application, 02 otherwise; else error.
// - application select data must be d2760000850101 exactly.
// - with 000c, e103 selects cc file and 0103 selects ndef file.
// - with 020c any two-byte ef id is accepted.
// - le byte 0x00 present only for application select; else error.
// - select answer with p2 0c is only the two status bytes.
// - read is 0xb0; p1p2 give start address, le gives length.
// - read answer carries data then status; data only on normal end.
module tbh_core #(
  parameter logic [15:0] SW_OK = 16'h9000,
  parameter logic [15:0] SW_ERR_CLA = 16'h6e00,
  parameter logic [15:0] SW_ERR_INS = 16'h6d00,
  parameter logic [15:0] SW_ERR_P12 = 16'h6a86,
  parameter logic [15:0] SW_ERR_LC = 16'h6700,
  parameter logic [15:0] SW_ERR_LE = 16'h6c00,
  parameter logic [15:0] SW_ERR_DATA = 16'h6a82
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire tbh_pkg::tbh_byte_s rx_i,
  input wire logic [31:0] pupi_i,
  output tbh_pkg::tbh_byte_s tx_o,
  input wire logic tx_rdy_i,
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_data_i,
  output logic halted_o,
  output tbh_pkg::tbh_sel_e sel_o
);
  import tbh_pkg::*;

  // ==========================================
  // state
  typedef enum logic [1:0] {
    ST_LISTEN = 2'h0,
    ST_EXEC = 2'h1,
    ST_SEND = 2'h3
  } tbh_st_e;

  typedef enum logic [2:0] {
    PH_BYTE = 3'h0,
    PH_DATA = 3'h1,
    PH_SW1 = 3'h2,
    PH_SW2 = 3'h3,
    PH_CRC1 = 3'h4,
    PH_CRC2 = 3'h5,
    PH_DONE = 3'h6
  } tbh_ph_e;

  tbh_st_e st_ff;
  tbh_ph_e ph_ff;
  logic [7:0] buf_ff [TBH_BUF_DEPTH];
  logic [4:0] cnt_ff;
  logic ovf_ff;
  logic [15:0] rcrc_ff;
  logic [15:0] tcrc_ff;
  logic [15:0] nxt_rcrc;
  logic [7:0] ans_ff;
  logic [15:0] sw_ff;
  logic [7:0] left_ff;
  logic pend_ff;
  logic dec_drop;
  logic frame_done;
  tbh_byte_s tx_ff;

  // ==========================================
  // receive: bytes are only taken while listening (half duplex)
  wire rx_take = rx_i.vld && st_ff == ST_LISTEN && !halted_o;
  assign nxt_rcrc = tbh_crc_upd(rcrc_ff, rx_i.data);
  // a frame ends when decode drops it or when its last answer byte is gone
  assign frame_done = (st_ff == ST_EXEC && dec_drop) || (st_ff == ST_SEND && ph_ff == PH_DONE && !tx_ff.vld);

  // frame collector; overflow marks the frame for dropping
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 5'h00;
      ovf_ff <= 1'b0;
      rcrc_ff <= TBH_CRC_INIT;
    end else if (rx_take) begin
      if (rx_i.last) begin
        // a bad residue drops the frame here, so its count must not leak into the next one
        if (nxt_rcrc != TBH_CRC_GOOD) begin
          cnt_ff <= 5'h00;
          ovf_ff <= 1'b0;
        end
        rcrc_ff <= TBH_CRC_INIT;
      end else begin
        cnt_ff <= (cnt_ff == TBH_BUF_DEPTH) ? cnt_ff : cnt_ff + 5'h01;
        ovf_ff <= ovf_ff | (cnt_ff == TBH_BUF_DEPTH);
        rcrc_ff <= nxt_rcrc;
      end
    end else if (frame_done) begin
      cnt_ff <= 5'h00;
      ovf_ff <= 1'b0;
    end
  end

  // byte store; the last byte is written too, count stays and decode adds one
  always_ff @(posedge clk_i) begin
    if (rx_take && !ovf_ff && cnt_ff != TBH_BUF_DEPTH) begin
      buf_ff[cnt_ff[3:0]] <= rx_i.data;
    end
  end

  // ==========================================
  // decode of a stored frame (valid in exec)
  wire [4:0] flen = cnt_ff + 5'h01;
  wire [4:0] alen = flen - TBH_LEN_CRC;
  wire [15:0] p12 = {buf_ff[2], buf_ff[3]};
  wire [15:0] fid = {buf_ff[5], buf_ff[6]};
  wire [55:0] aid = {buf_ff[5], buf_ff[6], buf_ff[7], buf_ff[8], buf_ff[9], buf_ff[10], buf_ff[11]};
  wire [31:0] hid = {buf_ff[1], buf_ff[2], buf_ff[3], buf_ff[4]};

  logic dec_one;
  logic dec_halt;
  logic dec_read;
  logic [7:0] dec_ans;
  logic [15:0] dec_sw;
  tbh_sel_e dec_sel;

  always_comb begin
    dec_drop = 1'b0;
    dec_one = 1'b0;
    dec_halt = 1'b0;
    dec_read = 1'b0;
    dec_ans = TBH_HALT_ANS;
    dec_sw = SW_OK;
    dec_sel = sel_o;
    // a full count means the last byte found no room, so the frame is too long
    if (ovf_ff || cnt_ff == TBH_BUF_DEPTH || flen <= TBH_LEN_CRC) begin
      dec_drop = 1'b1;
    end else if (buf_ff[0] == TBH_CMD_ATTRIB) begin
      dec_one = 1'b1;
      dec_ans = {TBH_MBLI, TBH_CID_NONE};
    end else if (buf_ff[0] == TBH_CMD_HALT) begin
      // halt frame is code plus pupi; a foreign pupi gets silence
      if (alen == TBH_LEN_HALT && hid == pupi_i) begin
        dec_one = 1'b1;
        dec_halt = 1'b1;
      end else begin
        dec_drop = 1'b1;
      end
    end else if (alen < TBH_LEN_HDR - 5'h01) begin
      dec_drop = 1'b1;
    end else if (buf_ff[0] != TBH_CLA) begin
      dec_sw = SW_ERR_CLA;
    end else if (buf_ff[1] == TBH_INS_SELECT) begin
      // select: pair, then lc, then frame length (le), then data
      if (p12 != TBH_P12_EF && p12 != TBH_P12_APP && p12 != TBH_P12_FID) begin
        dec_sw = SW_ERR_P12;
      end else if (alen < TBH_LEN_HDR) begin
        dec_sw = SW_ERR_LC;
      end else if (p12 == TBH_P12_APP) begin
        if (buf_ff[4] != TBH_LC_APP) begin
          dec_sw = SW_ERR_LC;
        end else if (alen != TBH_LEN_APP || buf_ff[12] != TBH_LE_APP) begin
          dec_sw = SW_ERR_LE;
        end else if (aid != TBH_AID) begin
          dec_sw = SW_ERR_DATA;
        end else begin
          dec_sel = TBH_SEL_APP;
        end
      end else if (buf_ff[4] != TBH_LC_FID) begin
        dec_sw = SW_ERR_LC;
      end else if (alen != TBH_LEN_FID) begin
        dec_sw = SW_ERR_LE;
      end else if (p12 == TBH_P12_EF) begin
        dec_sel = TBH_SEL_EF;
      end else if (fid == TBH_FID_CC) begin
        dec_sel = TBH_SEL_CC;
      end else if (fid == TBH_FID_NDEF) begin
        dec_sel = TBH_SEL_NDEF;
      end else begin
        dec_sel = TBH_SEL_EF;
      end
    end else if (buf_ff[1] == TBH_INS_READ) begin
      // read: exactly header plus le, le within 1..251
      if (alen != TBH_LEN_HDR) begin
        dec_sw = SW_ERR_LE;
      end else if (buf_ff[4] < TBH_LE_MIN || buf_ff[4] > TBH_LE_MAX) begin
        dec_sw = SW_ERR_LE;
      end else begin
        dec_read = 1'b1;
      end
    end else begin
      dec_sw = SW_ERR_INS;
    end
  end

  // ==========================================
  // sequencer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= ST_LISTEN;
    end else begin
      case (st_ff)
        ST_LISTEN: begin
          if (rx_take && rx_i.last) begin
            // only a good residue moves on; bad frames vanish
            st_ff <= (nxt_rcrc == TBH_CRC_GOOD) ? ST_EXEC : ST_LISTEN;
          end
        end
        ST_EXEC: begin
          st_ff <= dec_drop ? ST_LISTEN : ST_SEND;
        end
        ST_SEND: begin
          if (frame_done) begin
            st_ff <= ST_LISTEN;
          end
        end
        default: begin
          st_ff <= ST_LISTEN;
        end
      endcase
    end
  end

  // halt and file selection, latched as the answer is chosen
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      halted_o <= 1'b0;
      sel_o <= TBH_SEL_NONE;
    end else if (st_ff == ST_EXEC && !dec_drop) begin
      halted_o <= halted_o | dec_halt;
      sel_o <= dec_sel;
    end
  end

  // ==========================================
  // answer builder: one byte per free output slot
  wire slot = st_ff == ST_SEND && !tx_ff.vld;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_ff <= PH_BYTE;
      ans_ff <= 8'h00;
      sw_ff <= 16'h0000;
      left_ff <= 8'h00;
      pend_ff <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      tcrc_ff <= TBH_CRC_INIT;
      tx_ff <= '0;
    end else begin
      mem_rd_o <= 1'b0;
      if (tx_ff.vld && tx_rdy_i) begin
        tx_ff <= '0;
        // phase has already moved on; crc2 and done mean a crc byte was taken
        if (ph_ff != PH_CRC2 && ph_ff != PH_DONE) begin
          tcrc_ff <= tbh_crc_upd(tcrc_ff, tx_ff.data);
        end
      end
      if (st_ff == ST_EXEC) begin
        ans_ff <= dec_ans;
        sw_ff <= dec_sw;
        left_ff <= buf_ff[4];
        mem_addr_o <= p12;
        tcrc_ff <= TBH_CRC_INIT;
        // select answers are status only, never control info
        ph_ff <= dec_one ? PH_BYTE : (dec_read ? PH_DATA : PH_SW1);
      end else if (slot) begin
        case (ph_ff)
          PH_BYTE: begin
            tx_ff <= '{vld: 1'b1, last: 1'b0, data: ans_ff};
            ph_ff <= PH_CRC1;
          end
          PH_DATA: begin
            // memory answers one cycle after the strobe
            if (!pend_ff) begin
              pend_ff <= 1'b1;
              mem_rd_o <= 1'b1;
            end else begin
              pend_ff <= 1'b0;
              tx_ff <= '{vld: 1'b1, last: 1'b0, data: mem_data_i};
              mem_addr_o <= mem_addr_o + 16'h0001;
              left_ff <= left_ff - 8'h01;
              ph_ff <= (left_ff == 8'h01) ? PH_SW1 : PH_DATA;
            end
          end
          PH_SW1: begin
            tx_ff <= '{vld: 1'b1, last: 1'b0, data: sw_ff[15:8]};
            ph_ff <= PH_SW2;
          end
          PH_SW2: begin
            tx_ff <= '{vld: 1'b1, last: 1'b0, data: sw_ff[7:0]};
            ph_ff <= PH_CRC1;
          end
          PH_CRC1: begin
            tx_ff <= '{vld: 1'b1, last: 1'b0, data: ~tcrc_ff[7:0]};
            ph_ff <= PH_CRC2;
          end
          PH_CRC2: begin
            // high crc byte also waits for a free slot, keeping the idle gap
            tx_ff <= '{vld: 1'b1, last: 1'b1, data: ~tcrc_ff[15:8]};
            ph_ff <= PH_DONE;
          end
          PH_DONE: begin
            ph_ff <= PH_BYTE;
          end
          default: begin
            ph_ff <= PH_BYTE;
          end
        endcase
      end
    end
  end

  assign tx_o = tx_ff;
endmodule

// file: verification/tbh_core_monitor.sv
`timescale 1ns/100ps
// ==========================================
// port-level checks of the command handler
module tbh_core_monitor
  import tbh_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire tbh_pkg::tbh_byte_s rx_i,
  input wire logic [31:0] pupi_i,
  input wire tbh_pkg::tbh_byte_s tx_o,
  input wire logic tx_rdy_i,
  input wire logic mem_rd_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_data_i,
  input wire logic halted_o,
  input wire tbh_pkg::tbh_sel_e sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // a byte offered but not yet taken, and a byte taken
  sequence s_wait;
    tx_o.vld && !tx_rdy_i;
  endsequence
  sequence s_take;
    tx_o.vld && tx_rdy_i;
  endsequence
  tx_hold_a: assert property (s_wait |=> tx_o.vld && $stable(tx_o))
    else $error("answer byte changed before taken");
  tx_gap_a: assert property (s_take |=> !tx_o.vld)
    else $error("no idle cycle after taken byte");
  halt_keep_a: assert property (halted_o |=> halted_o)
    else $error("halt state left without reset");
  rd_pulse_a: assert property (mem_rd_o |=> !mem_rd_o)
    else $error("read strobe longer than one cycle");
  rd_data_a: assert property (mem_rd_o |=> ##[0:1] tx_o.vld)
    else $error("fetched byte not offered in time");
  reset_quiet_a: assert property ($rose(rstn_i) |-> !tx_o.vld && !mem_rd_o && !halted_o && sel_o == TBH_SEL_NONE)
    else $error("outputs not quiet after reset");
  rx_quiet_a: assert property (rx_i.vld |-> !tx_o.vld)
    else $error("answer sent while frame arrives");
  sel_steady_a: assert property (!$stable(sel_o) |-> !tx_o.vld)
    else $error("selection changed during answer");
endmodule

// file: verification/tbh_reader.sv
`timescale 1ns/100ps
// ==========================================
// reader model: sends frames with crc, collects answers
module tbh_reader
  import tbh_pkg::*;
(
  input wire logic clk_i,
  input wire tbh_pkg::tbh_byte_s tx_i,
  input wire logic slow_i,
  output tbh_pkg::tbh_byte_s rx_o,
  output logic rdy_o
);
  logic [7:0] ans[$];
  logic done;
  // own crc, returned complemented as it goes on the air
  function automatic logic [15:0] crcq(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return ~c;
  endfunction
  // one pulse per byte; idle line shows the inverse so stale data never looks valid
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crcq(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    ans.delete();
    done = 1'b0;
    foreach (q[i]) begin
      @(posedge clk_i);
      rx_o <= '{1'b1, i == q.size() - 1, q[i]};
      @(posedge clk_i);
      rx_o <= '{1'b0, 1'b0, ~q[i]};
    end
  endtask
  initial begin
    rx_o = '0;
    rdy_o = 1'b1;
    done = 1'b0;
  end
  // slow mode stalls every other cycle to test holding of answer bytes
  always @(posedge clk_i) begin
    rdy_o <= slow_i ? ~rdy_o : 1'b1;
    if (tx_i.vld && rdy_o) begin
      ans.push_back(tx_i.data);
      if (tx_i.last) done <= 1'b1;
    end
  end
endmodule

// file: verification/tbh_core_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module tbh_core_bench;
  import tbh_pkg::*;
  logic clk_i, rstn_i, slow, rdy, mem_rd, halted;
  logic [7:0] mem_data;
  logic [15:0] mem_addr;
  logic [7:0] none[$];
  logic [7:0] app[$] = '{8'h00, 8'ha4, 8'h04, 8'h00, 8'h07, 8'hd2, 8'h76, 8'h00, 8'h00, 8'h85, 8'h01, 8'h01, 8'h00};
  logic [7:0] atb[$] = '{8'h1d, 8'h1a, 8'h2b, 8'h3c, 8'h4d, 8'h00, 8'h08, 8'h01, 8'h00};
  tbh_byte_s rx, tx;
  tbh_sel_e sel;
  logic [7:0] big[$] = '{8'h00, 8'ha4, 8'h04, 8'h00, 8'h07, 8'hd2, 8'h76, 8'h00, 8'h00, 8'h85, 8'h01, 8'h01,
    8'h00, 8'h00, 8'h00};
  int num_errors, checks, cyc, strobes;
  tbh_core dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .rx_i(rx), .pupi_i(32'h1a2b3c4d), .tx_o(tx), .tx_rdy_i(rdy), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr),
    .mem_data_i(mem_data), .halted_o(halted), .sel_o(sel));
  tbh_reader rdr_u (.clk_i(clk_i), .tx_i(tx), .slow_i(slow), .rx_o(rx), .rdy_o(rdy));
  // memory answers the cycle after the strobe; pattern ties data to address
  // data follows the held address, so it stands by the edge after the strobe
  always @(posedge clk_i) begin
    mem_data <= mem_addr[7:0] ^ 8'h3c;
    if (mem_rd) strobes++;
  end
  // ==========================================
  // shared transfer and close
  task automatic close_out();
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // empty want means silence; waits out the bound in that case
  task automatic xfer(input logic [7:0] cmd[$], input logic [7:0] want[$], input logic bad = 1'b0);
    logic [15:0] c;
    int n;
    rdr_u.send(cmd, bad);
    for (n = 0; !rdr_u.done && n < 3000; n++) @(posedge clk_i);
    if (want.size() != 0) begin
      c = rdr_u.crcq(want);
      want.push_back(c[7:0]);
      want.push_back(c[15:8]);
    end
    `CHK(rdr_u.ans.size(), want.size())
    foreach (want[i]) `CHK(rdr_u.ans[i], want[i])
    repeat (3) @(posedge clk_i);
  endtask
  // ==========================================
  // scenarios
  task automatic fsel(input logic [7:0] cla, input logic [15:0] p, input logic [7:0] lc, input logic [15:0] f,
      input logic [15:0] sw);
    xfer('{cla, 8'ha4, p[15:8], p[7:0], lc, f[15:8], f[7:0]}, '{sw[15:8], sw[7:0]});
  endtask
  task automatic t_select();
    xfer(app, '{8'h90, 8'h00});
    `CHK(sel, TBH_SEL_APP)
    fsel(8'h00, 16'h000c, 8'h02, 16'he103, 16'h9000);
    `CHK(sel, TBH_SEL_CC)
    fsel(8'h00, 16'h000c, 8'h02, 16'h0103, 16'h9000);
    `CHK(sel, TBH_SEL_NDEF)
    fsel(8'h00, 16'h020c, 8'h02, 16'he103, 16'h9000);
    `CHK(sel, TBH_SEL_EF)
    fsel(8'h01, 16'h000c, 8'h02, 16'he103, 16'h6e00);
    fsel(8'h00, 16'h010c, 8'h02, 16'he103, 16'h6a86);
    fsel(8'h00, 16'h0400, 8'h02, 16'hd276, 16'h6700);
    fsel(8'h00, 16'h000c, 8'h07, 16'he103, 16'h6700);
    xfer('{8'h00, 8'ha4, 8'h00, 8'h0c, 8'h02, 8'he1, 8'h03, 8'h00}, '{8'h6c, 8'h00});
    app[11] = 8'h02;
    xfer(app, '{8'h6a, 8'h82});
    app[11] = 8'h01;
    void'(app.pop_back());
    xfer(app, '{8'h6c, 8'h00});
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] le, input logic [7:0] cla, input logic [15:0] sw);
    logic [7:0] w[$];
    logic [15:0] t;
    int s0;
    for (int i = 0; sw == 16'h9000 && i < le; i++) begin
      t = a + 16'(i);
      w.push_back(t[7:0] ^ 8'h3c);
    end
    w.push_back(sw[15:8]);
    w.push_back(sw[7:0]);
    s0 = strobes;
    xfer('{cla, 8'hb0, a[15:8], a[7:0], le}, w);
    `CHK(strobes - s0, (sw == 16'h9000) ? int'(le) : 0)
  endtask
  // ==========================================
  // main sequence
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    rstn_i = 1'b0;
    slow = 1'b0;
    mem_data = 8'h00;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    xfer(atb, '{8'h10});
    xfer(atb, none, 1'b1);
    t_select();
    slow <= 1'b1;
    rd(16'h0120, 8'h03, 8'h00, 16'h9000);
    rd(16'h00f8, 8'hfb, 8'h00, 16'h9000);
    rd(16'h0000, 8'hf0, 8'h00, 16'h9000);
    rd(16'h0010, 8'h00, 8'h00, 16'h6c00);
    rd(16'h0010, 8'hfc, 8'h00, 16'h6c00);
    rd(16'h0010, 8'h04, 8'h80, 16'h6e00);
    xfer('{8'h00, 8'h12, 8'h00, 8'h00, 8'h01}, '{8'h6d, 8'h00});
    // seventeen bytes with crc overrun the store: the frame must vanish
    xfer(big, none);
    slow <= 1'b0;
    xfer('{8'h50, 8'h1a, 8'h2b, 8'h3c, 8'h4e}, none);
    `CHK(halted, 1'b0)
    xfer('{8'h50, 8'h1a, 8'h2b, 8'h3c, 8'h4d}, '{8'h00});
    `CHK(halted, 1'b1)
    xfer(atb, none);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(sel, TBH_SEL_NONE)
    close_out();
  end
endmodule
bind tbh_core tbh_core_monitor mon_u (.clk_i(clk_i), .rstn_i(rstn_i), .rx_i(rx_i), .pupi_i(pupi_i), .tx_o(tx_o),
  .tx_rdy_i(tx_rdy_i), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i),
  .halted_o(halted_o), .sel_o(sel_o));
